// ===== lpu_pkg.sv
// Package of the pixel unpack and palette stage: register map, field
// positions, mode codes and the carrier structs.
// Assumes a single 50 MHz core clock and an AXI4-Lite register bus.
package lpu_pkg;

  // ****************************************************************
  // Register map and bus constants
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [1:0] PAL_WINDOW = 2'h1;
  localparam int PAL_SEL_MSB = 11;
  localparam int PAL_SEL_LSB = 10;
  localparam int PAL_IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Control fields, mode codes and datapath sizes
  // ****************************************************************
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_DEPTH_LSB = 2;
  localparam int CTRL_ORDER_BIT = 5;
  localparam int CTRL_EN_BIT = 6;
  localparam logic [1:0] DISP_STN_MONO = 2'h0;
  localparam logic [1:0] DISP_STN_COLOR = 2'h1;
  localparam logic [1:0] DISP_TFT = 2'h2;
  localparam logic [2:0] DEPTH_1 = 3'h0;
  localparam logic [2:0] DEPTH_2 = 3'h1;
  localparam logic [2:0] DEPTH_4 = 3'h2;
  localparam logic [2:0] DEPTH_8 = 3'h3;
  localparam logic [2:0] DEPTH_16 = 3'h4;
  localparam logic [2:0] DEPTH_24 = 3'h5;
  localparam logic ORDER_LE = 1'b0;
  localparam logic ORDER_BE = 1'b1;
  localparam int WORD_W = 32;
  localparam int BUF_W = 56;
  localparam int PIX_W = 24;
  localparam int ENTRY_W = 16;
  localparam int LUT_DEPTH = 256;
  localparam logic [5:0] BUF_ROOM = 6'h18;

  // ****************************************************************
  // Palette entry fields and panel lane positions
  // ****************************************************************
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 5;
  localparam int BLUE_LSB = 10;
  localparam int INTENS_BIT = 15;
  localparam int LANE_RED_LSB = 0;
  localparam int LANE_GREEN_LSB = 8;
  localparam int LANE_BLUE_LSB = 16;

  typedef struct packed {
    logic en;
    logic memory_order_select;
    logic [2:0] pixel_depth_select;
    logic [1:0] display_type_select;
  } lpu_ctrl_type;

  typedef struct packed {
    lpu_ctrl_type ctrl;
    logic aw_have;
    logic [11:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [55:0] bits;
    logic [5:0] cnt;
    logic pix_valid;
    logic [23:0] panel_data_bus;
  } lpu_state_type;

endpackage

// ===== lpu_unpack.sv
// Pixel unpack and palette lookup stage of a panel controller datapath.
// Assumes words arrive from a FIFO on the same clock with valid/ready,
// and the dithering or shifter stage takes pixels with valid/ready.
// Functional notes
// R1: Little-endian order takes the first pixel from the word's low bits.
// R2: Big-endian order takes the first pixel from bit 31 downward.
// R3: Palettized pixels of 1, 2, 4 or 8 bits index one table entry.
// R4: Palette use follows display type and pixel depth, else pass-through.
// R5: Every table entry can be written and read back by the host.
// R6: Entries sit in the low half of aligned words; upper bits are ignored.
// R7: The table holds 256 entries of 16 bits, all programmable.
// R8: An entry holds red 4:0, green 9:5, blue 14:10, intensity 15.
// R9: Monochrome STN uses the upper four red bits only.
// R10: Colour STN uses the upper four bits of red, green and blue.
// R11: TFT uses all five bits of each colour field.
// R12: TFT intensity drives panel lines 18, 10 and 2 together.
// R13: TFT palettized unused lines 17:16, 9:8 and 1:0 are held at zero.
// R14: Pixel width and word order follow the control register settings.
// R15: TFT colour fields sit in the upper five bits of each 8-bit lane.
`timescale 1ns/1ns
module lpu_unpack
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [11:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] I_WORD_DATA,
  input wire logic I_WORD_VALID,
  output logic O_WORD_READY,
  output logic [23:0] O_PANEL_DATA_BUS,
  output logic O_PIX_VALID,
  input wire logic I_PIX_READY
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Bits per pixel for a depth code.
  function automatic logic [5:0] pix_width(input logic [2:0] d);
    logic [5:0] w;
    w = 6'h01;
    unique case (d)
      lpu_pkg::DEPTH_2: w = 6'h02;
      lpu_pkg::DEPTH_4: w = 6'h04;
      lpu_pkg::DEPTH_8: w = 6'h08;
      lpu_pkg::DEPTH_16: w = 6'h10;
      lpu_pkg::DEPTH_24: w = 6'h18;
      default: w = 6'h01;
    endcase
    return w;
  endfunction

  // True when the display type and depth use the lookup table.
  function automatic logic is_pal(input lpu_pkg::lpu_ctrl_type c);
    logic p;
    if (c.display_type_select == lpu_pkg::DISP_STN_MONO)
      p = c.pixel_depth_select <= lpu_pkg::DEPTH_2; // [R4]
    else
      p = c.pixel_depth_select <= lpu_pkg::DEPTH_8; // [R4]
    return p;
  endfunction

  // Whether an address falls in the palette window.
  function automatic logic in_pal(input logic [11:0] a);
    return a[lpu_pkg::PAL_SEL_MSB:lpu_pkg::PAL_SEL_LSB]
      == lpu_pkg::PAL_WINDOW;
  endfunction

  // Palette index from an address.
  function automatic logic [7:0] pal_idx(input logic [11:0] a);
    return a[lpu_pkg::PAL_IDX_LSB +: 8];
  endfunction

  // ****************************************************************
  // State, palette memory and combinational wires
  // ****************************************************************
  lpu_pkg::lpu_state_type state_reg;
  lpu_pkg::lpu_state_type state_next;
  logic [15:0] pal_mem [lpu_pkg::LUT_DEPTH];
  logic pal_we;
  logic [7:0] pal_widx;
  logic [15:0] pal_wdata;
  logic [5:0] width;
  logic emit;
  logic take;
  logic [23:0] raw;
  logic [15:0] entry;
  logic [23:0] fmt;

  // Bus handshakes stall while an answer is still pending.
  assign O_AWREADY = !state_reg.aw_have && !state_reg.bvalid;
  assign O_WREADY = !state_reg.w_have && !state_reg.bvalid;
  assign O_ARREADY = !state_reg.rvalid;
  assign O_BVALID = state_reg.bvalid;
  assign O_BRESP = state_reg.bresp;
  assign O_RVALID = state_reg.rvalid;
  assign O_RDATA = state_reg.rdata;
  assign O_RRESP = state_reg.rresp;
  assign O_PIX_VALID = state_reg.pix_valid;
  assign O_PANEL_DATA_BUS = state_reg.panel_data_bus;

  // Width and order track the control register; a word is taken only
  // while the bit buffer has room for all 32 of its bits.
  assign width = pix_width(state_reg.ctrl.pixel_depth_select); // [R14]
  assign emit = state_reg.ctrl.en && (state_reg.cnt >= width)
    && (!state_reg.pix_valid || I_PIX_READY);
  assign O_WORD_READY = state_reg.ctrl.en
    && (state_reg.cnt <= lpu_pkg::BUF_ROOM);
  assign take = I_WORD_VALID && O_WORD_READY;

  // ****************************************************************
  // Pixel extraction and colour formatting
  // ****************************************************************

  // Little-endian pixels come from the bottom of the buffer, big-endian
  // ones from the top; 24-bit pixels may straddle two words.
  always_comb
  begin
    logic [55:0] sh;
    sh = state_reg.bits; // [R1]
    if (state_reg.ctrl.memory_order_select == lpu_pkg::ORDER_BE)
      sh = state_reg.bits >> (6'(lpu_pkg::BUF_W) - width); // [R2]
    raw = sh[lpu_pkg::PIX_W-1:0] & ~(24'hFFFFFF << width);
  end

  // Palettized pixels index the table; others pass through unchanged.
  always_comb
  begin
    entry = pal_mem[raw[7:0]]; // [R3]
    fmt = raw; // [R4]
    if (is_pal(state_reg.ctrl))
    begin
      fmt = '0;
      unique case (state_reg.ctrl.display_type_select)
        lpu_pkg::DISP_STN_MONO:
          fmt[3:0] = entry[lpu_pkg::RED_LSB+1 +: 4]; // [R9] [R8]
        lpu_pkg::DISP_STN_COLOR:
        begin
          fmt[3:0] = entry[lpu_pkg::RED_LSB+1 +: 4]; // [R10]
          fmt[7:4] = entry[lpu_pkg::GREEN_LSB+1 +: 4]; // [R10]
          fmt[11:8] = entry[lpu_pkg::BLUE_LSB+1 +: 4]; // [R10]
        end
        default:
        begin
          // Five-bit fields fill the top of each lane, intensity below.
          fmt[lpu_pkg::LANE_RED_LSB+3 +: 5] =
            entry[lpu_pkg::RED_LSB +: 5]; // [R11] [R15]
          fmt[lpu_pkg::LANE_GREEN_LSB+3 +: 5] =
            entry[lpu_pkg::GREEN_LSB +: 5]; // [R11] [R15]
          fmt[lpu_pkg::LANE_BLUE_LSB+3 +: 5] =
            entry[lpu_pkg::BLUE_LSB +: 5]; // [R11] [R15]
          fmt[lpu_pkg::LANE_RED_LSB+2] = entry[lpu_pkg::INTENS_BIT]; // [R12]
          fmt[lpu_pkg::LANE_GREEN_LSB+2] = entry[lpu_pkg::INTENS_BIT]; // [R12]
          fmt[lpu_pkg::LANE_BLUE_LSB+2] = entry[lpu_pkg::INTENS_BIT]; // [R12]
        end
      endcase
    end
  end

  // ****************************************************************
  // Next-state logic: register bus and pixel buffer
  // ****************************************************************

  // Write address and data are taken in either order; the response
  // follows once both are held.
  always_comb
  begin
    logic [55:0] b;
    logic [5:0] c;
    b = state_reg.bits;
    c = state_reg.cnt;
    state_next = state_reg;
    pal_we = 1'b0;
    pal_widx = pal_idx(state_reg.awaddr);
    pal_wdata = state_reg.wdata[lpu_pkg::ENTRY_W-1:0]; // [R6]
    if (I_AWVALID && O_AWREADY)
    begin
      state_next.aw_have = 1'b1;
      state_next.awaddr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY)
    begin
      state_next.w_have = 1'b1;
      state_next.wdata = I_WDATA;
    end
    if (state_reg.aw_have && state_reg.w_have)
    begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = lpu_pkg::RESP_OKAY;
      if (in_pal(state_reg.awaddr))
        pal_we = 1'b1; // [R5] [R7]
      else if (state_reg.awaddr == lpu_pkg::CTRL_OFFSET)
        state_next.ctrl = state_reg.wdata[lpu_pkg::CTRL_EN_BIT:0]; // [R14]
      else if (state_reg.awaddr != lpu_pkg::STATUS_OFFSET)
        state_next.bresp = lpu_pkg::RESP_SLVERR;
    end
    if (state_reg.bvalid && I_BREADY)
      state_next.bvalid = 1'b0;

    // Reads answer one cycle after the address is taken.
    if (I_ARVALID && O_ARREADY)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp = lpu_pkg::RESP_OKAY;
      state_next.rdata = '0;
      if (in_pal(I_ARADDR))
        state_next.rdata[15:0] = pal_mem[pal_idx(I_ARADDR)]; // [R5] [R6]
      else if (I_ARADDR == lpu_pkg::CTRL_OFFSET)
        state_next.rdata[lpu_pkg::CTRL_EN_BIT:0] = state_reg.ctrl;
      else if (I_ARADDR == lpu_pkg::STATUS_OFFSET)
        state_next.rdata[7:0] = {is_pal(state_reg.ctrl),
          state_reg.pix_valid, state_reg.cnt};
      else
        state_next.rresp = lpu_pkg::RESP_SLVERR;
    end
    else if (state_reg.rvalid && I_RREADY)
      state_next.rvalid = 1'b0;

    // Pixels leave before the new word enters, so room is judged on
    // the count at the start of the cycle.
    if (state_reg.pix_valid && I_PIX_READY)
      state_next.pix_valid = 1'b0;
    if (emit)
    begin
      state_next.pix_valid = 1'b1;
      state_next.panel_data_bus = fmt;
      c = c - width;
      if (state_reg.ctrl.memory_order_select == lpu_pkg::ORDER_LE)
        b = b >> width; // [R1]
      else
        b = b << width; // [R2]
    end
    if (take)
    begin
      if (state_reg.ctrl.memory_order_select == lpu_pkg::ORDER_LE)
        b = b | ({24'h000000, I_WORD_DATA} << c); // [R1]
      else
        b = b | ({I_WORD_DATA, 24'h000000} >> c); // [R2]
      c = c + 6'(lpu_pkg::WORD_W);
    end
    state_next.bits = b;
    state_next.cnt = c;
    // Disabling flushes partial words so a new mode starts aligned.
    if (!state_reg.ctrl.en)
    begin
      state_next.bits = '0;
      state_next.cnt = '0;
      state_next.pix_valid = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // All control state in one register.
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // The palette has no reset: software loads it before enabling.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (pal_we)
      pal_mem[pal_widx] <= pal_wdata; // [R5] [R7]
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  le_first_pixel_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    take && !emit && state_reg.cnt == 6'h00
    && state_reg.ctrl.memory_order_select == lpu_pkg::ORDER_LE
    |=> state_reg.bits[7:0] == $past(I_WORD_DATA[7:0])) // [R1]
    else $error("Little-endian word not at buffer bottom.");
  be_first_pixel_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    take && !emit && state_reg.cnt == 6'h00
    && state_reg.ctrl.memory_order_select == lpu_pkg::ORDER_BE
    |=> state_reg.bits[55:48] == $past(I_WORD_DATA[31:24])) // [R2]
    else $error("Big-endian word not at buffer top.");
  width_follow_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    emit && !take && state_reg.ctrl.en ##1 state_reg.ctrl.en
    |-> state_reg.cnt == $past(state_reg.cnt) - $past(width)) // [R14]
    else $error("Buffer count does not drop by the pixel width.");
  tft_intensity_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    emit && is_pal(state_reg.ctrl)
    && state_reg.ctrl.display_type_select == lpu_pkg::DISP_TFT
    |=> O_PANEL_DATA_BUS[18] == $past(entry[15])
    && O_PANEL_DATA_BUS[10] == O_PANEL_DATA_BUS[18]
    && O_PANEL_DATA_BUS[2] == O_PANEL_DATA_BUS[18]) // [R12]
    else $error("Intensity bit not on all three lanes.");
  tft_zero_lines_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    emit && is_pal(state_reg.ctrl)
    && state_reg.ctrl.display_type_select == lpu_pkg::DISP_TFT
    |=> O_PANEL_DATA_BUS[17:16] == 2'h0 && O_PANEL_DATA_BUS[9:8] == 2'h0
    && O_PANEL_DATA_BUS[1:0] == 2'h0) // [R13]
    else $error("Unused TFT lines not zero.");
  mono_gray_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    emit && is_pal(state_reg.ctrl)
    && state_reg.ctrl.display_type_select == lpu_pkg::DISP_STN_MONO
    |=> O_PANEL_DATA_BUS == {20'h00000, $past(entry[4:1])}) // [R9]
    else $error("Monochrome shade not from upper red bits.");
  pal_write_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    pal_we |=> pal_mem[$past(pal_widx)] == $past(state_reg.wdata[15:0])
    && O_BVALID) // [R5]
    else $error("Palette write not stored.");
  pal_read_upper_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RST)
    I_ARVALID && O_ARREADY && in_pal(I_ARADDR)
    |=> O_RVALID && O_RDATA[31:16] == 16'h0000) // [R6]
    else $error("Palette read upper half not zero.");
  bresp_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("Write response dropped before taken.");

endmodule

// ===== lpu_sink.sv
// Partner model: the dithering stage that takes formatted pixels.
// Assumes it shares the core clock and reset of the unpack stage.
`timescale 1ns/1ns
module lpu_sink
(
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_ready
);
  logic [1:0] ph_reg;

  // Stall one cycle in four, so the stage must hold a pixel that waits.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ph_reg <= 2'h0;
    else
      ph_reg <= ph_reg + 2'h1;
  end

  // Ready is low only in phase three of every four cycles.
  assign o_ready = (ph_reg != 2'h3);
endmodule

// ===== tb_lpu_unpack.sv
// Testbench of the pixel unpack and palette stage.
// Assumes lpu_pkg, lpu_unpack and lpu_sink are compiled before it.
`timescale 1ns/1ns
module tb_lpu_unpack;
  // ****************************************************************
  // Signals, design and partner
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, word = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic rready = 1'b0, word_v = 1'b0, pix_rdy;
  logic awr, wr, bv, arr, rv, word_rdy, pv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] pix;
  logic [15:0] pal [256];
  logic [23:0] q [$];
  logic [5:0] modes [15] = '{6'h20, 6'h23, 6'h24, 6'h26, 6'h27, 6'h29,
    6'h2A, 6'h2B, 6'h01, 6'h02, 6'h04, 6'h13, 6'h14, 6'h17, 6'h18};
  int n_mismatch = 0;
  int checks = 0;

  always #10 clk = ~clk;

  lpu_unpack i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(bresp), .O_BVALID(bv),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
    .I_RREADY(rready), .I_WORD_DATA(word), .I_WORD_VALID(word_v),
    .O_WORD_READY(word_rdy), .O_PANEL_DATA_BUS(pix), .O_PIX_VALID(pv),
    .I_PIX_READY(pix_rdy));

  lpu_sink i_sink (.i_clk(clk), .i_rst(rst), .o_ready(pix_rdy));

  // A pixel offered with ready high is taken at the next rising edge;
  // looking before that edge keeps the monitor clear of the update.
  always @(negedge clk)
  begin
    if (pv === 1'b1 && pix_rdy === 1'b1)
      q.push_back(pix);
  end

  // ****************************************************************
  // Shared tasks; each bus task starts and ends just after an edge
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ta, tw;
  begin
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    forever
    begin
      @(negedge clk);
      if (!awv && !wv)
        break;
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
    end
    // Ready comes one cycle late, so the response must stand meanwhile.
    while (bv !== 1'b1)
      @(negedge clk);
    r = bresp;
    @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
  end
  endtask

  task automatic rd32(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
  begin
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    // Read ready stays up, so back-to-back reads never toggle it.
    @(posedge clk);
  end
  endtask

  // Valid stays up between words; the caller lowers it after the last.
  task automatic send(input logic [31:0] w);
  begin
    word <= w;
    word_v <= 1'b1;
    do @(negedge clk); while (word_rdy !== 1'b1);
    @(posedge clk);
  end
  endtask

  // Expected panel value of one pixel, from the bench's palette copy.
  function automatic logic [23:0] fmt(input logic [1:0] dt,
    input logic [2:0] dp, input logic [23:0] p);
    logic [15:0] e;
    logic pz;
  begin
    e = pal[p[7:0]];
    pz = (dt == lpu_pkg::DISP_STN_MONO) ? (dp <= lpu_pkg::DEPTH_2)
      : (dp <= lpu_pkg::DEPTH_8);
    if (!pz)
      return p;
    if (dt == lpu_pkg::DISP_TFT)
      return {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0, e[4:0],
        e[15], 2'h0};
    if (dt == lpu_pkg::DISP_STN_COLOR)
      return {12'h000, e[14:11], e[9:6], e[4:1]};
    return {20'h00000, e[4:1]};
  end
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
  begin
    chk(32'(word_rdy), 32'h0);
    rd32(lpu_pkg::CTRL_OFFSET, d, r);
    chk(d, 32'h0);
    rd32(12'h800, d, r);
    chk(32'(r), 32'(lpu_pkg::RESP_SLVERR));
    wr32(12'h008, 32'h1, r);
    chk(32'(r), 32'(lpu_pkg::RESP_SLVERR));
    wr32(lpu_pkg::STATUS_OFFSET, 32'hFF, r);
    chk(32'(r), 32'(lpu_pkg::RESP_OKAY));
    // Idle and reset control: mono 1 bpp counts as palettized.
    rd32(lpu_pkg::STATUS_OFFSET, d, r);
    chk(d, 32'h80);
    $display("test regs done");
  end
  endtask

  // The upper half of each write is junk and must not be stored.
  task automatic test_pal;
    logic [31:0] d;
    logic [1:0] r;
  begin
    for (int i = 0; i < 256; i++)
    begin
      pal[i] = 16'(i * 40503 + 7);
      wr32({lpu_pkg::PAL_WINDOW, 8'(i), 2'h0}, {16'hFFFF, pal[i]}, r);
      chk(32'(r), 32'(lpu_pkg::RESP_OKAY));
    end
    for (int i = 0; i < 256; i++)
    begin
      rd32({lpu_pkg::PAL_WINDOW, 8'(i), 2'h0}, d, r);
      chk(d, {16'h0000, pal[i]});
    end
    $display("test pal done");
  end
  endtask

  // Three words make a whole number of pixels at every depth.
  task automatic run_mode(input logic [1:0] dt, input logic [2:0] dp,
    input logic ord);
    logic [95:0] bits, le;
    logic [31:0] d, cw;
    logic [1:0] r;
    logic [23:0] p;
    int bpp, n;
  begin
    bpp = (dp == lpu_pkg::DEPTH_24) ? 24 : (1 << dp);
    n = 96 / bpp;
    cw = {25'h0, 1'b1, ord, dp, dt};
    bits = {32'h1E5AC387, 32'h6B2F90D4, 32'hC3A5F01E} ^ {3{cw}};
    le = {bits[31:0], bits[63:32], bits[95:64]};
    wr32(lpu_pkg::CTRL_OFFSET, cw, r);
    rd32(lpu_pkg::CTRL_OFFSET, d, r);
    chk(d, cw);
    q.delete();
    send(bits[95:64]);
    send(bits[63:32]);
    send(bits[31:0]);
    word_v <= 1'b0;
    for (int c = 0; c < 2000 && q.size() < n; c++)
      @(posedge clk);
    chk(32'(q.size()), 32'(n));
    for (int k = 0; k < n && k < q.size(); k++)
    begin
      p = (ord == lpu_pkg::ORDER_BE) ? 24'(bits >> (96 - (k + 1) * bpp))
        : 24'(le >> (k * bpp));
      p = p & 24'((1 << bpp) - 1);
      chk(32'(q[k]), 32'(fmt(dt, dp, p)));
      // Field use and lane placement.
    end
    wr32(lpu_pkg::CTRL_OFFSET, 32'h0, r);
    @(negedge clk);
    chk(32'(word_rdy), 32'h0);
    @(posedge clk);
    $display("test mode %h done", cw[5:0]);
  end
  endtask

  // ****************************************************************
  // Main sequence, verdict and watchdog
  // ****************************************************************
  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_regs();
    test_pal();
    foreach (modes[m])
      run_mode(modes[m][5:4], modes[m][3:1], modes[m][0]);
    test_done();
  end

  // About 2,500 cycles are expected; eight times that means a hang.
  initial
  begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule
